/* File: design/light_conv_params.svh */
`ifndef LIGHT_CONV_PARAMS_SVH
`define LIGHT_CONV_PARAMS_SVH

// ---------------------------------------------------------------
// register indices (byte address = 4 x index)
// ---------------------------------------------------------------
`define RES_IDX        8'h00
`define CFG_IDX        8'h01
`define LOW_IDX        8'h02
`define HIGH_IDX       8'h03
`define IRQ_STAT_IDX   8'h04
`define IRQ_EN_IDX     8'h05
`define IRQ_CLR_IDX    8'h06

// ---------------------------------------------------------------
// configuration field positions
// ---------------------------------------------------------------
`define CFG_RANGE_LSB  12
`define CFG_PERIOD_BIT 11
`define CFG_MODE_LSB   9
`define CFG_OVF_BIT    8
`define CFG_DONE_BIT   7
`define CFG_HIGH_BIT   6
`define CFG_LOW_BIT    5
`define CFG_LATCH_BIT  4
`define CFG_POL_BIT    3
`define CFG_MASK_BIT   2
`define CFG_FAULT_LSB  0

// ---------------------------------------------------------------
// reset values and range codes
// ---------------------------------------------------------------
`define RANGE_AUTO     4'hc
`define RANGE_MAX      4'hb
`define PERIOD_RST     1'b1
`define LATCH_RST      1'b1
`define LOW_LIM_RST    16'h0000
`define HIGH_LIM_RST   16'hbfff
`define IRQ_BITS       4

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ         50000000
`define CONV_SHORT_MS  100
`define CONV_LONG_MS   800

`endif

/* File: design/light_conv_pkg.sv */
package light_conv_pkg;

    // conversion mode field encoding
    typedef enum logic [1:0] {
        MODE_OFF  = 2'b00,
        MODE_ONCE = 2'b01,
        MODE_RUN  = 2'b10,
        MODE_RUN2 = 2'b11
    } mode_t;

    // sequencer states
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } seq_state_t;

    // consecutive measurements needed per fault count choice
    function automatic logic [3:0] faultNeed(input logic [1:0] choice);
        unique case (choice)
            2'b00: faultNeed = 4'h1;
            2'b01: faultNeed = 4'h2;
            2'b10: faultNeed = 4'h4;
            2'b11: faultNeed = 4'h8;
        endcase
    endfunction : faultNeed

endpackage : light_conv_pkg

/* File: design/conv_timer.sv */
`timescale 1ns/1ps
module conv_timer
    import light_conv_pkg::*;
#(
    parameter int SHORT_CYCLES = 5000000,
    parameter int LONG_CYCLES  = 40000000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // control
    input  wire logic start,
    input  wire logic cancel,
    input  wire logic longSel,
    // status
    output logic      done
);
    localparam int CNT_W = $clog2(LONG_CYCLES + 1);

    // refuse periods the counter cannot serve, before any simulation starts
    if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES) begin : g_bad_period
        $error("conv_timer: bad period parameters");
    end

    logic [CNT_W-1:0] countR;   // cycles left in this conversion
    logic             runR;     // conversion in progress

    // reload on start; a restart mid-count simply begins again
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            countR <= '0;
            runR   <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                countR <= longSel ? CNT_W'(LONG_CYCLES - 1) : CNT_W'(SHORT_CYCLES - 1);
                runR   <= 1'b1;
            end else if (cancel) begin
                runR <= 1'b0;
            end else if (runR) begin
                if (countR == '0) begin
                    runR <= 1'b0;
                    done <= 1'b1;
                end else begin
                    countR <= countR - 1'b1;
                end
            end
        end
    end
endmodule : conv_timer

/* File: design/fault_streak.sv */
`timescale 1ns/1ps
module fault_streak
    import light_conv_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // measurement
    input  wire logic       measured,
    input  wire logic       beyond,
    input  wire logic [1:0] choice,
    // flag
    output logic            flag
);
    logic [3:0] streakR;   // consecutive measurements beyond the limit

    // flag sets only once the streak is long enough and clears on the first measurement within the limit;
    // nothing changes between measurements, so shutdown keeps it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            streakR <= 4'h0;
            flag    <= 1'b0;
        end else if (measured) begin
            if (!beyond) begin
                streakR <= 4'h0;
                flag    <= 1'b0;
            end else begin
                if (streakR != 4'hf)
                    streakR <= streakR + 4'h1;
                if (streakR + 4'h1 >= faultNeed(choice))
                    flag <= 1'b1;
            end
        end
    end
endmodule : fault_streak

/* File: design/light_conv_ctrl.sv */
//
// Summary of operation
// - mode 00 off, 01 once, 1x continuous
// - mode field resets to shutdown
// - single-shot mode reads back while converting
// - finished single-shot returns mode to shutdown
// - shutdown keeps ready, limit flags, alert
// - overflow bit recomputed every measurement
// - manual range: transient overload sets overflow
// - auto range: overflow only at maximum range
// - auto overload below max: abort, raise, restart
// - repeat until clean; overflow updated at end
// - ready bit set when conversion completes
// - ready cleared by read or non-shutdown write
// - high flag when result above high limit
// - high flag needs fault-count consecutive hits
// - range code 1100 is auto, reset value
// - fault count codes need 1,2,4,8 hits
// - low flag when result below low limit
// - period bit: 0 short, 1 long, reset 1
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "light_conv_params.svh"
module light_conv_ctrl
    import light_conv_pkg::*;
#(
    parameter int SHORT_CYCLES = `CONV_SHORT_MS * (`CLK_HZ / 1000),
    parameter int LONG_CYCLES  = `CONV_LONG_MS * (`CLK_HZ / 1000)
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // analog front end
    input  wire logic [15:0] sampleValue,
    input  wire logic        overloadIn,
    // status outputs
    output logic             convActive,
    output logic [3:0]       rangeOut,
    output logic             alertOut,
    output logic             irq
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    seq_state_t     stateR;            // sequencer state
    mode_t          modeR;             // conversion mode field
    logic [3:0]     rangeChoiceR;      // full-scale range choice
    logic           periodChoiceR;     // conversion period choice
    logic           ovfR;              // overload indicator
    logic           doneBitR;          // conversion done bit
    logic           latchR;            // stored, no behaviour here
    logic           polR;              // stored, no behaviour here
    logic           maskR;             // stored, no behaviour here
    logic [1:0]     faultChoiceR;      // fault count choice
    logic [15:0]    lowLimR;           // low limit
    logic [15:0]    highLimR;          // high limit
    logic [15:0]    resultR;           // last finished result
    logic           overloadSeenR;     // overload during this integration
    logic [`IRQ_BITS-1:0] irqStatR;    // sticky events
    logic [`IRQ_BITS-1:0] irqEnR;      // event enables
    logic           highPrevR;         // for edge detection
    logic           lowPrevR;          // for edge detection
    logic           wrPendR;           // write data phase pending
    logic [7:0]     wrIdxR;            // write register index

    logic           highFlag;          // above high limit bit
    logic           lowFlag;           // below low limit bit
    logic           timerDone;         // conversion time elapsed

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic       addrPhase;             // a transfer is taken this edge
    logic [7:0] addrIdx;               // word index of the address
    logic       cfgRead;               // config read taken
    logic       wrCfg;                 // config write data phase
    logic [15:0] cfgWord;              // config read value

    assign addrPhase = hsel && htrans[1] && hready;
    assign addrIdx   = haddr[9:2];
    assign cfgRead   = addrPhase && !hwrite && addrIdx == `CFG_IDX;
    assign wrCfg     = wrPendR && wrIdxR == `CFG_IDX;

    assign cfgWord = {rangeChoiceR, periodChoiceR, modeR, ovfR, doneBitR,
                      highFlag, lowFlag, latchR, polR, maskR, faultChoiceR};

    // ---------------------------------------------------------------
    // sequencer decode
    // ---------------------------------------------------------------
    logic autoRange;                   // automatic ranging selected
    logic abortConv;                   // overload step-up restart
    logic measDone;                    // a measurement finished cleanly
    logic stopReq;                     // host asked for shutdown
    logic startConv;                   // timer (re)start

    assign autoRange = rangeChoiceR == `RANGE_AUTO;
    assign stopReq   = stateR == ST_CONV && modeR == MODE_OFF;
    assign abortConv = stateR == ST_CONV && !stopReq && autoRange
                       && overloadIn && rangeOut < `RANGE_MAX;
    assign measDone  = stateR == ST_CONV && timerDone && !abortConv && !stopReq;
    assign startConv = (stateR == ST_IDLE && modeR != MODE_OFF) || abortConv
                       || (measDone && modeR[1]);

    // ---------------------------------------------------------------
    // ahb-lite slave: zero wait, registered read data
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wrPendR   <= 1'b0;
            wrIdxR    <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPendR   <= addrPhase && hwrite;
            wrIdxR    <= addrIdx;
            if (addrPhase && !hwrite) begin
                // unmapped addresses read as zero
                unique case (addrIdx)
                    `RES_IDX:      hrdata <= {16'h0000, resultR};
                    `CFG_IDX:      hrdata <= {16'h0000, cfgWord};
                    `LOW_IDX:      hrdata <= {16'h0000, lowLimR};
                    `HIGH_IDX:     hrdata <= {16'h0000, highLimR};
                    `IRQ_STAT_IDX: hrdata <= {28'h0000000, irqStatR};
                    `IRQ_EN_IDX:   hrdata <= {28'h0000000, irqEnR};
                    default:       hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // writable configuration fields
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rangeChoiceR  <= `RANGE_AUTO;
            periodChoiceR <= `PERIOD_RST;
            latchR        <= `LATCH_RST;
            polR          <= 1'b0;
            maskR         <= 1'b0;
            faultChoiceR  <= 2'b00;
            lowLimR       <= `LOW_LIM_RST;
            highLimR      <= `HIGH_LIM_RST;
            irqEnR        <= '0;
        end else if (wrPendR) begin
            if (wrCfg) begin
                // reserved range codes are refused, the old choice stays
                if (hwdata[`CFG_RANGE_LSB+:4] <= `RANGE_AUTO)
                    rangeChoiceR <= hwdata[`CFG_RANGE_LSB+:4];
                periodChoiceR <= hwdata[`CFG_PERIOD_BIT];
                latchR        <= hwdata[`CFG_LATCH_BIT];
                polR          <= hwdata[`CFG_POL_BIT];
                maskR         <= hwdata[`CFG_MASK_BIT];
                faultChoiceR  <= hwdata[`CFG_FAULT_LSB+:2];
            end
            if (wrIdxR == `LOW_IDX)
                lowLimR <= hwdata[15:0];
            if (wrIdxR == `HIGH_IDX)
                highLimR <= hwdata[15:0];
            if (wrIdxR == `IRQ_EN_IDX)
                irqEnR <= hwdata[`IRQ_BITS-1:0];
        end
    end

    // ---------------------------------------------------------------
    // mode field: host writes win over the single-shot return
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            modeR <= MODE_OFF;
        end else if (wrCfg) begin
            modeR <= mode_t'(hwdata[`CFG_MODE_LSB+:2]);
        end else if (measDone && modeR == MODE_ONCE) begin
            modeR <= MODE_OFF;
        end
    end

    // ---------------------------------------------------------------
    // sequencer state and active range
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateR     <= ST_IDLE;
            convActive <= 1'b0;
            rangeOut   <= 4'h0;
        end else begin
            unique case (stateR)
                ST_IDLE: begin
                    if (modeR != MODE_OFF) begin
                        stateR     <= ST_CONV;
                        convActive <= 1'b1;
                    end
                end
                ST_CONV: begin
                    // single-shot keeps reading back 01 until it ends
                    if (stopReq || (measDone && modeR == MODE_ONCE)) begin
                        stateR     <= ST_IDLE;
                        convActive <= 1'b0;
                    end
                end
            endcase
            // auto ranging always climbs from the lowest range
            if (abortConv)
                rangeOut <= rangeOut + 4'h1;
            else if (startConv)
                rangeOut <= autoRange ? 4'h0 : rangeChoiceR;
        end
    end

    conv_timer #(
        .SHORT_CYCLES (SHORT_CYCLES),
        .LONG_CYCLES  (LONG_CYCLES)
    ) u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (startConv),
        .cancel  (stopReq),
        .longSel (periodChoiceR),
        .done    (timerDone)
    );

    // ---------------------------------------------------------------
    // measurement results and overload indicator
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overloadSeenR <= 1'b0;
            ovfR          <= 1'b0;
            resultR       <= 16'h0000;
        end else begin
            // any overload during integration counts, even a spike
            if (startConv)
                overloadSeenR <= 1'b0;
            else if (stateR == ST_CONV && overloadIn)
                overloadSeenR <= 1'b1;
            // updated only when a measurement ends, not on abort
            if (measDone) begin
                resultR <= sampleValue;
                if (autoRange)
                    ovfR <= (overloadSeenR || overloadIn)
                            && rangeOut == `RANGE_MAX;
                else
                    ovfR <= overloadSeenR || overloadIn;
            end
        end
    end

    // ---------------------------------------------------------------
    // conversion done bit: a completion beats a clearing access
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            doneBitR <= 1'b0;
        else if (measDone)
            doneBitR <= 1'b1;
        else if (cfgRead || (wrCfg && hwdata[`CFG_MODE_LSB+:2] != MODE_OFF))
            doneBitR <= 1'b0;
    end

    // ---------------------------------------------------------------
    // limit comparison flags, only moved by measurements
    // ---------------------------------------------------------------
    fault_streak u_high (
        .clk      (clk),
        .reset_n  (reset_n),
        .measured (measDone),
        .beyond   (sampleValue > highLimR),
        .choice   (faultChoiceR),
        .flag     (highFlag)
    );

    fault_streak u_low (
        .clk      (clk),
        .reset_n  (reset_n),
        .measured (measDone),
        .beyond   (sampleValue < lowLimR),
        .choice   (faultChoiceR),
        .flag     (lowFlag)
    );

    // ---------------------------------------------------------------
    // interrupts: done, overflow, high rise, low rise
    // ---------------------------------------------------------------
    logic [`IRQ_BITS-1:0] irqEvents;   // one-cycle event pulses
    logic [`IRQ_BITS-1:0] irqClear;    // write-one-to-clear mask

    assign irqEvents = {lowFlag & ~lowPrevR, highFlag & ~highPrevR,
                        measDone & (overloadSeenR | overloadIn), measDone};
    assign irqClear  = (wrPendR && wrIdxR == `IRQ_CLR_IDX) ?
                       hwdata[`IRQ_BITS-1:0] : '0;

    // set wins over clear so no event is lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatR  <= '0;
            highPrevR <= 1'b0;
            lowPrevR  <= 1'b0;
            irq       <= 1'b0;
            alertOut  <= 1'b0;
        end else begin
            irqStatR  <= (irqStatR & ~irqClear) | irqEvents;
            highPrevR <= highFlag;
            lowPrevR  <= lowFlag;
            irq       <= |(irqStatR & irqEnR);
            alertOut  <= highFlag | lowFlag;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence sAbort;
        abortConv ##1 1'b1;
    endsequence

    a_single_autoclear: assert property (@(posedge clk) disable iff (!reset_n)
        measDone && modeR == MODE_ONCE && !wrCfg |=> modeR == MODE_OFF && !convActive)
        else $error("single-shot did not return to shutdown");

    a_single_holds: assert property (@(posedge clk) disable iff (!reset_n)
        stateR == ST_CONV && modeR == MODE_ONCE && !measDone && !wrCfg
        |=> modeR == MODE_ONCE)
        else $error("single-shot mode dropped early");

    a_done_sets: assert property (@(posedge clk) disable iff (!reset_n)
        measDone |=> doneBitR ##1 1'b1)
        else $error("done bit not set after conversion");

    a_read_clears: assert property (@(posedge clk) disable iff (!reset_n)
        cfgRead && !measDone |=> !doneBitR)
        else $error("config read did not clear done bit");

    a_shutdown_keeps: assert property (@(posedge clk) disable iff (!reset_n)
        wrCfg && hwdata[`CFG_MODE_LSB+:2] == 2'b00 && !measDone && !$past(measDone) && !cfgRead
        |=> doneBitR == $past(doneBitR) && alertOut == $past(alertOut)
            && highFlag == $past(highFlag) && lowFlag == $past(lowFlag))
        else $error("shutdown write disturbed status");

    a_auto_ovf: assert property (@(posedge clk) disable iff (!reset_n)
        measDone && autoRange && rangeOut != `RANGE_MAX |=> !ovfR)
        else $error("overflow below maximum auto range");

    a_abort_raise: assert property (@(posedge clk) disable iff (!reset_n)
        sAbort |-> rangeOut == $past(rangeOut) + 4'h1 && stateR == ST_CONV)
        else $error("abort did not raise range");

    a_ovf_hold_abort: assert property (@(posedge clk) disable iff (!reset_n)
        abortConv |=> $stable(ovfR))
        else $error("overflow changed on abort");

    a_run_restarts: assert property (@(posedge clk) disable iff (!reset_n)
        measDone && modeR[1] && !wrCfg |=> stateR == ST_CONV [*2])
        else $error("continuous mode did not restart");

    a_off_idle: assert property (@(posedge clk) disable iff (!reset_n)
        stateR == ST_IDLE && modeR == MODE_OFF |=> !convActive)
        else $error("conversion started in shutdown");

endmodule : light_conv_ctrl

/* File: test/front_end_model.sv */
`timescale 1ns/1ps
// stand-in for the analog front end that feeds the sequencer
module front_end_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // requests from bench and block
    input  wire logic        convActive,
    input  wire logic        ovlReq,
    input  wire logic [15:0] svIn,
    // front end outputs
    output logic      [15:0] sampleValue,
    output logic             overloadIn
);
    // idle sample toggles so a stale value never passes for a fresh one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sampleValue <= 16'h0000;
            overloadIn  <= 1'b0;
        end else begin
            sampleValue <= convActive ? svIn : ~sampleValue;
            overloadIn  <= ovlReq & convActive;
        end
    end
endmodule : front_end_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
`define CHK(n,e,s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
    import light_conv_pkg::*;
    // bus, front end and status signals
    logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, ovlReq, overloadIn;
    logic        convActive, alertOut, irq;
    logic [1:0]  htrans;
    logic [3:0]  rangeOut;
    logic [15:0] svIn, sampleValue, lim;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_mismatch = 0;
    int          num_checks = 0;
    // short conversion counts keep the run brief
    light_conv_ctrl #(.SHORT_CYCLES(20), .LONG_CYCLES(40)) DUT (.clk(clk), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .sampleValue(sampleValue), .overloadIn(overloadIn),
        .convActive(convActive), .rangeOut(rangeOut), .alertOut(alertOut), .irq(irq));
    front_end_model FE (.clk(clk), .reset_n(reset_n), .convActive(convActive),
        .ovlReq(ovlReq), .svIn(svIn), .sampleValue(sampleValue), .overloadIn(overloadIn));
    task automatic give_verdict();
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    // an exhausted wait counts as a mismatch and ends the run
    task automatic lapse(input int n);
        if (n >= 999) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : lapse
    // one single ahb-lite word transfer; read data left in rd
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 999);
        lapse(n);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 999);
        lapse(n);
        rd = hrdata;
    endtask : bus
    function automatic logic [31:0] cfg(input logic [3:0] r, input logic [1:0] m, f);
        return {16'h0, r, 1'b0, m, 7'h0, f};
    endfunction : cfg
    // high flag needs two exceeding shots in a row with fault count 01
    function automatic logic hiExp(input logic [15:0] s, l, input int k);
        return (k == 1) && (s > l);
    endfunction : hiExp
    // wait for a conversion to start (if not yet) and to finish, plus one edge for irq
    task automatic convWait();
        int n = 0;
        while (convActive !== 1'b1 && n < 9) begin @(posedge clk); #1; n++; end
        while (convActive !== 1'b0 && n < 999) begin @(posedge clk); #1; n++; end
        lapse(n);
        @(posedge clk);
        #1;
    endtask : convWait
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {reset_n, hsel, hwrite, ovlReq, htrans, haddr, hwdata, svIn} = '0;
        void'($urandom(32'h0580));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        bus(0, 8'h01, 0);
        `CHK("cfg reset", 32'hc810, rd)
        `CHK("hresp", 1'b0, hresp)
        bus(0, 8'h3f, 0);
        `CHK("unmapped", 32'h0, rd)
        bus(1, 8'h05, 1);
        lim = 16'($urandom);
        svIn <= 16'($urandom);
        bus(1, 8'h03, {16'h0, lim});
        for (int k = 0; k < 2; k++) begin
            bus(1, 8'h01, cfg(4'h0, 2'h1, 2'h1));
            bus(0, 8'h01, 0);
            `CHK("mode busy", 2'h1, rd[10:9])
            convWait();
            `CHK("irq set", 1'b1, irq)
            bus(1, 8'h06, 1);
            @(posedge clk);
            #1;
            `CHK("irq clr", 1'b0, irq)
            bus(1, 8'h01, cfg(4'h0, 2'h0, 2'h1));
            bus(0, 8'h01, 0);
            `CHK("mode end", 2'h0, rd[10:9])
            `CHK("done kept", 1'b1, rd[7])
            `CHK("high", hiExp(svIn, lim, k), rd[6])
            `CHK("alert", hiExp(svIn, lim, k), alertOut)
            bus(0, 8'h01, 0);
            `CHK("done clr", 1'b0, rd[7])
        end
        // manual and automatic range, each with and without overload
        bus(1, 8'h02, 32'h0000ffff);
        for (int i = 0; i < 4; i++) begin
            ovlReq <= i[0];
            bus(1, 8'h01, cfg(i[1] ? 4'hc : 4'h0, 2'h1, 2'h0));
            convWait();
            bus(0, 8'h01, 0);
            `CHK("ovf", i[0], rd[8])
            `CHK("low", svIn != 16'hffff, rd[5])
            `CHK("range", (i == 3) ? 4'hb : 4'h0, rangeOut)
        end
        ovlReq <= 1'b0;
        for (int m = 2; m < 4; m++) begin
            bus(1, 8'h01, cfg(4'h0, m[1:0], 2'h0));
            bus(0, 8'h01, 0);
            `CHK("cont mode", m[1:0], rd[10:9])
            repeat (30) @(posedge clk);
            #1;
            `CHK("cont run", 1'b1, convActive)
            // clear the done bit, then a later completion must set it again
            bus(0, 8'h01, 0);
            repeat (30) @(posedge clk);
            bus(0, 8'h01, 0);
            `CHK("cont again", 1'b1, rd[7])
            bus(1, 8'h01, cfg(4'h0, 2'h0, 2'h0));
            convWait();
        end
        give_verdict();
    end
endmodule : testbench
